// ==== inc/rpvb_defines.svh ====
`ifndef RPVB_DEFINES_SVH
`define RPVB_DEFINES_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define RPVB_OFS_LOAD 8'h0E
`define RPVB_OFS_MISM 8'h0F
`define RPVB_OFS_CFG 8'h10
`define RPVB_OFS_CPL 8'h11
`define RPVB_OFS_CPM 8'h12
`define RPVB_OFS_CPH 8'h13
`define RPVB_OFS_THR 8'h14
`define RPVB_OFS_CLR 8'h15
`define RPVB_OFS_DP 8'h16
`define RPVB_OFS_FLAG 8'h17
`define RPVB_OFS_CNT0 8'h18
// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define RPVB_CFG_CP20_BIT 7
`define RPVB_CFG_LEN_LSB 3
`define RPVB_CLR_ALIGN_BIT 7
`define RPVB_CLR_ECC_BIT 4
`define RPVB_CLR_LFC_BIT 3
`define RPVB_DP_EN_LSB 4
`define RPVB_RST_BYTE 8'h00
`define RPVB_RST_NIB 4'h0
`define RPVB_RST_CP 20'h00000
`define RPVB_CLK_PAT 20'h55555
`define RPVB_CP16_MASK 20'h0FFFF
`define RPVB_CP20_MASK 20'hFFFFF
`endif

// ==== inc/rpvb_pkg.sv ====
`default_nettype none
package rpvb_pkg;
  typedef enum logic [2:0] {
    RPVB_PSEL_OFF = 3'b000,
    RPVB_PSEL_PRBS = 3'b001,
    RPVB_PSEL_CLOCK = 3'b010,
    RPVB_PSEL_CUSTOM = 3'b011
  } rpvb_psel_t;
  typedef enum logic [2:0] {
    RPVB_LEN_7 = 3'b000,
    RPVB_LEN_11 = 3'b001,
    RPVB_LEN_23 = 3'b010,
    RPVB_LEN_31 = 3'b011,
    RPVB_LEN_15A = 3'b100,
    RPVB_LEN_15B = 3'b101,
    RPVB_LEN_20A = 3'b110,
    RPVB_LEN_20B = 3'b111
  } rpvb_len_t;
  typedef enum logic [2:0] {
    RPVB_DP_DISP = 3'b000,
    RPVB_DP_FIFO = 3'b001,
    RPVB_DP_OVF = 3'b010,
    RPVB_DP_UNF = 3'b011,
    RPVB_DP_DESKEW = 3'b100
  } rpvb_dpsel_t;
  typedef enum logic [2:0] {
    RPVB_IS_MISMATCH = 3'b000,
    RPVB_IS_EVENT = 3'b001,
    RPVB_IS_NONZERO = 3'b010,
    RPVB_IS_THRESH = 3'b011
  } rpvb_isrc_t;
endpackage : rpvb_pkg
`default_nettype wire

// ==== hdl/rpvb_lane.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rpvb_defines.svh"
module rpvb_lane #(
  parameter int WORD_W = 20
) (
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic cfg_load,
  input wire logic [2:0] cfg_sel,
  input wire logic [2:0] cfg_len,
  input wire logic cfg_cp20,
  input wire logic [WORD_W-1:0] cfg_cp,
  input wire logic dp_mode,
  input wire logic dp_evt,
  input wire logic [WORD_W-1:0] rx_word,
  input wire logic rx_valid,
  output logic err_toggle,
  output logic live_level
);
  logic [2:0] sel_q;
  logic [2:0] len_q;
  logic cp20_q;
  logic [WORD_W-1:0] cp_q;
  logic [30:0] hist_q;
  logic [30:0] hist_d;
  logic prbs_bad;
  logic mis;
  logic evt;
  int tap_a;
  int tap_b;
  // ---------------------------------------------------------------
  // settings capture
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      sel_q <= 3'h0;
      len_q <= 3'h0;
      cp20_q <= 1'b0;
      cp_q <= `RPVB_RST_CP;
    end else if (cfg_load) begin
      sel_q <= cfg_sel;
      len_q <= cfg_len;
      cp20_q <= cfg_cp20;
      cp_q <= cfg_cp;
    end
  end
  // ---------------------------------------------------------------
  // self-synchronising sequence check
  // ---------------------------------------------------------------
  always_comb begin
    case (rpvb_pkg::rpvb_len_t'(len_q))
      rpvb_pkg::RPVB_LEN_7: begin tap_a = 7; tap_b = 6; end
      rpvb_pkg::RPVB_LEN_11: begin tap_a = 11; tap_b = 9; end
      rpvb_pkg::RPVB_LEN_23: begin tap_a = 23; tap_b = 18; end
      rpvb_pkg::RPVB_LEN_31: begin tap_a = 31; tap_b = 28; end
      rpvb_pkg::RPVB_LEN_15A, rpvb_pkg::RPVB_LEN_15B: begin tap_a = 15; tap_b = 14; end
      default: begin tap_a = 20; tap_b = 3; end
    endcase
  end
  always_comb begin
    hist_d = hist_q;
    prbs_bad = 1'b0;
    for (int i = 0; i < WORD_W; i++) begin
      if (rx_word[i] != (hist_d[tap_a-1] ^ hist_d[tap_b-1])) begin
        prbs_bad = 1'b1;
      end
      hist_d = {hist_d[29:0], rx_word[i]};
    end
  end
  always_comb begin
    case (rpvb_pkg::rpvb_psel_t'(sel_q))
      rpvb_pkg::RPVB_PSEL_PRBS: mis = prbs_bad;
      rpvb_pkg::RPVB_PSEL_CLOCK: mis = (rx_word != `RPVB_CLK_PAT) && (rx_word != ~`RPVB_CLK_PAT);
      rpvb_pkg::RPVB_PSEL_CUSTOM: mis = ((rx_word ^ cp_q) &
        (cp20_q ? `RPVB_CP20_MASK : `RPVB_CP16_MASK)) != '0;
      default: mis = 1'b0;
    endcase
  end
  assign evt = dp_mode ? dp_evt : (rx_valid & mis);
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      hist_q <= 31'h0;
    end else if (rx_valid) begin
      hist_q <= hist_d;
    end
  end
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      err_toggle <= 1'b0;
      live_level <= 1'b0;
    end else begin
      err_toggle <= err_toggle ^ evt;
      live_level <= dp_mode ? dp_evt : (rx_valid ? mis : live_level);
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_hold_settings;
    @(posedge link_clk) disable iff (link_rst)
    !cfg_load |=> (sel_q == $past(sel_q)) && (cp_q == $past(cp_q));
  endproperty
  a_hold_settings: assert property (p_hold_settings) else $error("settings moved without load");
  property p_cp16_ignores_nibble;
    @(posedge link_clk) disable iff (link_rst)
    (sel_q == 3'b011) && !cp20_q && (rx_word[15:0] == cp_q[15:0]) && rx_valid && !dp_mode
      |=> err_toggle == $past(err_toggle);
  endproperty
  a_cp16_ignores_nibble: assert property (p_cp16_ignores_nibble) else $error("16-bit match counted");
endmodule : rpvb_lane
`default_nettype wire

// ==== hdl/rpvb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rpvb_defines.svh"
module rpvb_top #(
  parameter int LANES = 4,
  parameter int WORD_W = 20,
  parameter int CNT_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic link_clk,
  input wire logic [LANES*WORD_W-1:0] rx_word,
  input wire logic [LANES-1:0] rx_valid,
  input wire logic [LANES-1:0] disparity_err,
  input wire logic [LANES-1:0] fifo_err,
  input wire logic [LANES-1:0] fifo_overflow,
  input wire logic [LANES-1:0] fifo_underflow,
  input wire logic lane_align_done
);
  localparam int CFG_W = LANES + 3 + 3 + 1 + WORD_W + 3 + LANES;
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  // ---------------------------------------------------------------
  // registers in the clk domain
  // ---------------------------------------------------------------
  logic [LANES-1:0] lane_settings_load_q;
  logic custom_width_sel_q;
  logic [2:0] sequence_length_q;
  logic [2:0] pattern_select_q;
  logic [WORD_W-1:0] custom_pattern_q;
  logic [2:0] retain_threshold_q;
  logic error_counter_clear_q;
  logic latched_flag_clear_q;
  logic [2:0] test_irq_source_q;
  logic [LANES-1:0] datapath_check_enable_q;
  logic [2:0] datapath_check_select_q;
  logic [LANES-1:0] live_test_flag_q;
  logic [LANES-1:0] latched_test_flag_q;
  logic [CNT_W-1:0] lane_error_count_q [LANES];
  logic [LANES-1:0] live_src;
  logic wr_load;
  logic wr_cfg;
  logic wr_clr;
  assign wr_load = reg_wr && (reg_addr == `RPVB_OFS_LOAD);
  assign wr_cfg = reg_wr && (reg_addr == `RPVB_OFS_CFG);
  assign wr_clr = reg_wr && (reg_addr == `RPVB_OFS_CLR);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lane_settings_load_q <= `RPVB_RST_NIB;
      custom_width_sel_q <= 1'b0;
      sequence_length_q <= 3'h0;
      pattern_select_q <= 3'h0;
      custom_pattern_q <= `RPVB_RST_CP;
      retain_threshold_q <= 3'h0;
      test_irq_source_q <= 3'h0;
      datapath_check_enable_q <= `RPVB_RST_NIB;
      datapath_check_select_q <= 3'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `RPVB_OFS_LOAD: lane_settings_load_q <= reg_wdata[LANES-1:0];
        `RPVB_OFS_CFG: begin
          custom_width_sel_q <= reg_wdata[`RPVB_CFG_CP20_BIT];
          sequence_length_q <= reg_wdata[`RPVB_CFG_LEN_LSB+:3];
          pattern_select_q <= reg_wdata[2:0];
        end
        `RPVB_OFS_CPL: custom_pattern_q[7:0] <= reg_wdata;
        `RPVB_OFS_CPM: custom_pattern_q[15:8] <= reg_wdata;
        `RPVB_OFS_CPH: custom_pattern_q[19:16] <= reg_wdata[3:0];
        `RPVB_OFS_THR: retain_threshold_q <= reg_wdata[2:0];
        `RPVB_OFS_CLR: test_irq_source_q <= reg_wdata[2:0];
        `RPVB_OFS_DP: begin
          datapath_check_enable_q <= reg_wdata[`RPVB_DP_EN_LSB+:LANES];
          datapath_check_select_q <= reg_wdata[2:0];
        end
        default: ;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // self-clearing clear bits
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      error_counter_clear_q <= 1'b0;
      latched_flag_clear_q <= 1'b0;
    end else begin
      error_counter_clear_q <= wr_clr && reg_wdata[`RPVB_CLR_ECC_BIT];
      latched_flag_clear_q <= wr_clr && reg_wdata[`RPVB_CLR_LFC_BIT];
    end
  end
  // ---------------------------------------------------------------
  // link domain reset and settings crossing
  // ---------------------------------------------------------------
  logic [1:0] link_rst_sync_q;
  logic link_rst;
  logic [CFG_W-1:0] cfg_bus;
  logic [CFG_W-1:0] cfg_s1_q;
  logic [CFG_W-1:0] cfg_s2_q;
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      link_rst_sync_q <= 2'b11;
    end else begin
      link_rst_sync_q <= {link_rst_sync_q[0], 1'b0};
    end
  end
  assign link_rst = link_rst_sync_q[1];
  assign cfg_bus = {datapath_check_enable_q, datapath_check_select_q, custom_pattern_q,
                    custom_width_sel_q, sequence_length_q, pattern_select_q,
                    lane_settings_load_q};
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      cfg_s1_q <= '0;
      cfg_s2_q <= '0;
    end else begin
      cfg_s1_q <= cfg_bus;
      cfg_s2_q <= cfg_s1_q;
    end
  end
  logic [LANES-1:0] l_load;
  logic [2:0] l_sel;
  logic [2:0] l_len;
  logic l_cp20;
  logic [WORD_W-1:0] l_cp;
  logic [2:0] l_dpsel;
  logic [LANES-1:0] l_dpen;
  assign {l_dpen, l_dpsel, l_cp, l_cp20, l_len, l_sel, l_load} = cfg_s2_q;
  // ---------------------------------------------------------------
  // datapath condition select
  // ---------------------------------------------------------------
  logic [LANES-1:0] dp_cond;
  logic [LANES-1:0] dp_mode;
  logic [LANES-1:0] dp_evt;
  always_comb begin
    case (rpvb_pkg::rpvb_dpsel_t'(l_dpsel))
      rpvb_pkg::RPVB_DP_DISP: dp_cond = disparity_err;
      rpvb_pkg::RPVB_DP_FIFO: dp_cond = fifo_err;
      rpvb_pkg::RPVB_DP_OVF: dp_cond = fifo_overflow;
      rpvb_pkg::RPVB_DP_UNF: dp_cond = fifo_underflow;
      rpvb_pkg::RPVB_DP_DESKEW: dp_cond = {LANES{~lane_align_done}};
      default: dp_cond = '0;
    endcase
  end
  always_comb begin
    dp_mode = l_dpen;
    dp_evt = l_dpen & dp_cond;
    dp_mode[0] = |l_dpen;
    dp_evt[0] = |(l_dpen & dp_cond);
  end
  // ---------------------------------------------------------------
  // lane checkers
  // ---------------------------------------------------------------
  logic [LANES-1:0] err_toggle;
  logic [LANES-1:0] live_level;
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    rpvb_lane #(
      .WORD_W(WORD_W)
    ) u_lane (
      .link_clk(link_clk),
      .link_rst(link_rst),
      .cfg_load(l_load[g]),
      .cfg_sel(l_sel),
      .cfg_len(l_len),
      .cfg_cp20(l_cp20),
      .cfg_cp(l_cp),
      .dp_mode(dp_mode[g]),
      .dp_evt(dp_evt[g]),
      .rx_word(rx_word[g*WORD_W+:WORD_W]),
      .rx_valid(rx_valid[g]),
      .err_toggle(err_toggle[g]),
      .live_level(live_level[g])
    );
  end
  // ---------------------------------------------------------------
  // crossing back into the clk domain
  // ---------------------------------------------------------------
  logic [LANES-1:0] tgl_s1_q;
  logic [LANES-1:0] tgl_s2_q;
  logic [LANES-1:0] tgl_s3_q;
  logic [LANES-1:0] live_s1_q;
  logic [LANES-1:0] live_s2_q;
  logic align_s1_q;
  logic align_s2_q;
  logic [LANES-1:0] lane_evt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tgl_s1_q <= '0;
      tgl_s2_q <= '0;
      tgl_s3_q <= '0;
      live_s1_q <= '0;
      live_s2_q <= '0;
      align_s1_q <= 1'b0;
      align_s2_q <= 1'b0;
    end else begin
      tgl_s1_q <= err_toggle;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      live_s1_q <= live_level;
      live_s2_q <= live_s1_q;
      align_s1_q <= lane_align_done;
      align_s2_q <= align_s1_q;
    end
  end
  assign lane_evt = tgl_s2_q ^ tgl_s3_q;
  // ---------------------------------------------------------------
  // error counters and flags
  // ---------------------------------------------------------------
  for (genvar c = 0; c < LANES; c++) begin : g_cnt
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        lane_error_count_q[c] <= '0;
      end else if (error_counter_clear_q) begin
        lane_error_count_q[c] <= '0;
      end else if (lane_evt[c] && (lane_error_count_q[c] != CNT_MAX)) begin
        lane_error_count_q[c] <= lane_error_count_q[c] + 1'b1;
      end
    end
    always_comb begin
      case (rpvb_pkg::rpvb_isrc_t'(test_irq_source_q))
        rpvb_pkg::RPVB_IS_MISMATCH: live_src[c] = live_s2_q[c];
        rpvb_pkg::RPVB_IS_EVENT: live_src[c] = lane_evt[c];
        rpvb_pkg::RPVB_IS_NONZERO: live_src[c] = lane_error_count_q[c] != '0;
        rpvb_pkg::RPVB_IS_THRESH:
          live_src[c] = lane_error_count_q[c] >= (CNT_W'(1) << retain_threshold_q);
        default: live_src[c] = ~align_s2_q;
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      live_test_flag_q <= '0;
      latched_test_flag_q <= '0;
    end else begin
      live_test_flag_q <= live_src;
      latched_test_flag_q <= (latched_test_flag_q & ~{LANES{latched_flag_clear_q}}) |
                             live_test_flag_q;
    end
  end
  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `RPVB_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `RPVB_OFS_LOAD: reg_rdata <= {4'h0, lane_settings_load_q};
        `RPVB_OFS_MISM: reg_rdata <= {live_s2_q, 4'h0};
        `RPVB_OFS_CFG: reg_rdata <= {custom_width_sel_q, 1'b0, sequence_length_q,
                                     pattern_select_q};
        `RPVB_OFS_CPL: reg_rdata <= custom_pattern_q[7:0];
        `RPVB_OFS_CPM: reg_rdata <= custom_pattern_q[15:8];
        `RPVB_OFS_CPH: reg_rdata <= {4'h0, custom_pattern_q[19:16]};
        `RPVB_OFS_THR: reg_rdata <= {5'h00, retain_threshold_q};
        `RPVB_OFS_CLR: reg_rdata <= {align_s2_q, 2'b00, error_counter_clear_q,
                                     latched_flag_clear_q, test_irq_source_q};
        `RPVB_OFS_DP: reg_rdata <= {datapath_check_enable_q, 1'b0, datapath_check_select_q};
        `RPVB_OFS_FLAG: reg_rdata <= {latched_test_flag_q, live_test_flag_q};
        `RPVB_OFS_CNT0: reg_rdata <= lane_error_count_q[0][7:0];
        default: reg_rdata <= `RPVB_RST_BYTE;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_cnt_clear;
    @(posedge clk) disable iff (rst)
    wr_clr && reg_wdata[`RPVB_CLR_ECC_BIT] |=> ##1 lane_error_count_q[0] == '0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("count not cleared");
  property p_clr_selfclear;
    @(posedge clk) disable iff (rst)
    error_counter_clear_q && !wr_clr |=> !error_counter_clear_q;
  endproperty
  a_clr_selfclear: assert property (p_clr_selfclear) else $error("clear bit stuck");
  property p_latch_set;
    @(posedge clk) disable iff (rst)
    live_test_flag_q[0] |=> latched_test_flag_q[0];
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latched flag missed");
  property p_latch_clear;
    @(posedge clk) disable iff (rst)
    latched_flag_clear_q && (live_test_flag_q == '0) |=> latched_test_flag_q == '0;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latched flag not cleared");
  property p_saturate;
    @(posedge clk) disable iff (rst)
    (lane_error_count_q[0] == CNT_MAX) && !error_counter_clear_q
      |=> lane_error_count_q[0] == CNT_MAX;
  endproperty
  a_saturate: assert property (p_saturate) else $error("counter wrapped");
  property p_increment;
    @(posedge clk) disable iff (rst)
    lane_evt[0] && !error_counter_clear_q && (lane_error_count_q[0] != CNT_MAX)
      |=> lane_error_count_q[0] == $past(lane_error_count_q[0]) + 1'b1;
  endproperty
  a_increment: assert property (p_increment) else $error("count not advanced");
  property p_read_count;
    @(posedge clk) disable iff (rst)
    reg_rd && (reg_addr == `RPVB_OFS_CNT0) |=> reg_rdata == $past(lane_error_count_q[0][7:0]);
  endproperty
  a_read_count: assert property (p_read_count) else $error("count byte wrong");
  property p_read_align;
    @(posedge clk) disable iff (rst)
    reg_rd && (reg_addr == `RPVB_OFS_CLR) |=> reg_rdata[`RPVB_CLR_ALIGN_BIT] == $past(align_s2_q);
  endproperty
  a_read_align: assert property (p_read_align) else $error("align bit wrong");
  property p_read_flags;
    @(posedge clk) disable iff (rst)
    reg_rd && (reg_addr == `RPVB_OFS_FLAG)
      |=> reg_rdata == $past({latched_test_flag_q, live_test_flag_q});
  endproperty
  a_read_flags: assert property (p_read_flags) else $error("flag byte wrong");
  c_count_event: cover property (@(posedge clk) disable iff (rst) lane_evt[0]);
  c_latched: cover property (@(posedge clk) disable iff (rst) latched_test_flag_q[0]);
  c_clear: cover property (@(posedge clk) disable iff (rst)
    error_counter_clear_q && (lane_error_count_q[0] != '0));
endmodule : rpvb_top
`default_nettype wire

// ==== tb/rpvb_link_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// serial transmitter stand-in, link domain
// ---------------------------------------------
module rpvb_link_model (
  input wire logic link_clk,
  output logic [79:0] rx_word,
  output logic [3:0] rx_valid,
  output logic [15:0] evt,
  output logic align_done
);
  initial begin
    rx_word = '0;
    rx_valid = '0;
    evt = '0;
    align_done = 1'b0;
  end
  // lines change on the falling link edge; idle words show the inverse
  task automatic send(input logic [19:0] w, input logic [3:0] l, input int n);
    repeat (n) begin
      @(negedge link_clk);
      rx_word = {4{w}};
      rx_valid = l;
    end
    @(negedge link_clk);
    rx_valid = '0;
    rx_word = ~rx_word;
  endtask : send
  // lets freshly written enable and select settings reach the link side first
  task automatic pulse(input int k, input logic [3:0] l, input int n);
    repeat (4) @(negedge link_clk);
    repeat (n) begin
      @(negedge link_clk);
      evt = 16'(l) << (4 * k);
    end
    @(negedge link_clk);
    evt = 16'h0000;
  endtask : pulse
  task automatic set_align(input logic b);
    @(negedge link_clk);
    align_done = b;
  endtask : set_align
endmodule : rpvb_link_model
`default_nettype wire

// ==== tb/rpvb_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module rpvb_bench;
  logic clk = 0, lclk = 0, rst = 1, wr = 0, rd = 0;
  logic [7:0] ra = 8'h00, wd = 8'h00, rdat, v;
  logic [79:0] rxw;
  logic [3:0] rxv;
  logic [15:0] ev;
  logic ad;
  logic [19:0] w;
  logic [31:0] h;
  int n_mismatch = 0, n_compared = 0, e;
  localparam logic [31:0] ACC [9] = '{32'h10FFFFBF, 32'h11FFFFFF, 32'h12FFFFFF,
    32'h13FFFF0F, 32'h14FFFF07, 32'h15FFE707, 32'h16FFFFF7, 32'h17FFFFFF, 32'h18FFFF00};
  localparam logic [27:0] MODE [6] = '{28'h0255555, 28'h02AAAAA, 28'h0212345,
    28'h0012345, 28'h0412345, 28'h0712345};
  localparam int TA [8] = '{7, 11, 23, 31, 15, 15, 20, 20};
  localparam int TB [8] = '{6, 9, 18, 28, 14, 14, 3, 3};
  initial forever #50 clk = ~clk;
  initial begin
    #37;
    forever #62.5 lclk = ~lclk;
  end
  rpvb_top u_rpvb_top (.clk(clk), .rst(rst), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdat), .link_clk(lclk), .rx_word(rxw), .rx_valid(rxv),
    .disparity_err(ev[3:0]), .fifo_err(ev[7:4]), .fifo_overflow(ev[11:8]),
    .fifo_underflow(ev[15:12]), .lane_align_done(ad));
  rpvb_link_model u_rpvb_link_model (.link_clk(lclk), .rx_word(rxw), .rx_valid(rxv),
    .evt(ev), .align_done(ad));
  // ---------------------------------------------
  // register access and checking
  // ---------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    ra = a;
    wd = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    ra = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    d = rdat;
  endtask : rd_reg
  task automatic check(input string nm, input logic [7:0] s, input logic [7:0] x);
    n_compared++;
    if (s !== x) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask : check
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
    rd_reg(a, v);
    check($sformatf("reg %h", a), v & m, x);
  endtask : rchk
  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // bounded poll; a bound used up ends the run
  task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
    repeat (6) @(negedge clk);
    for (int i = 0; i < 40; i++) begin
      rd_reg(a, v);
      if ((v & m) === x) break;
    end
    check($sformatf("poll %h", a), v & m, x);
    if ((v & m) !== x) summarize();
  endtask : poll
  task automatic load(input logic [7:0] cfg, input logic [7:0] lanes);
    wr_reg(8'h10, cfg);
    wr_reg(8'h0E, lanes);
    repeat (8) @(negedge clk);
    wr_reg(8'h0E, 8'h00);
  endtask : load
  task automatic clr(input logic [7:0] src);
    wr_reg(8'h15, 8'h10 | src);
    wr_reg(8'h15, src);
    repeat (6) @(negedge clk);
  endtask : clr
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    for (int a = 14; a <= 24; a++) rchk(a[7:0], 8'hFF, 8'h00);
    rchk(8'h40, 8'hFF, 8'h00);
    foreach (ACC[i]) begin
      wr_reg(ACC[i][31:24], ACC[i][23:16]);
      rchk(ACC[i][31:24], ACC[i][15:8], ACC[i][7:0]);
    end
    foreach (ACC[i]) wr_reg(ACC[i][31:24], 8'h00);
    wr_reg(8'h15, 8'h08);
    rchk(8'h17, 8'hFF, 8'h00);
    u_rpvb_link_model.set_align(1);
    poll(8'h15, 8'h80, 8'h80);
    u_rpvb_link_model.set_align(0);
    poll(8'h15, 8'h80, 8'h00);
    $display("test registers done");
    wr_reg(8'h11, 8'h3C);
    wr_reg(8'h12, 8'h5A);
    wr_reg(8'h13, 8'h0F);
    load(8'h03, 8'h03);
    u_rpvb_link_model.send(20'h05A3C, 4'h1, 4);
    poll(8'h18, 8'hFF, 8'h00);
    u_rpvb_link_model.send(20'h05A3D, 4'h1, 3);
    poll(8'h18, 8'hFF, 8'h03);
    rchk(8'h17, 8'h10, 8'h10);
    wr_reg(8'h10, 8'h00);
    u_rpvb_link_model.send(20'h00000, 4'h1, 2);
    poll(8'h18, 8'hFF, 8'h05);
    load(8'h83, 8'h01);
    u_rpvb_link_model.send(20'h05A3C, 4'h1, 2);
    poll(8'h18, 8'hFF, 8'h07);
    wr_reg(8'h14, 8'h03);
    wr_reg(8'h15, 8'h03);
    poll(8'h17, 8'h01, 8'h00);
    wr_reg(8'h14, 8'h02);
    poll(8'h17, 8'h01, 8'h01);
    wr_reg(8'h15, 8'h02);
    poll(8'h17, 8'h01, 8'h01);
    clr(8'h02);
    poll(8'h18, 8'hFF, 8'h00);
    rchk(8'h17, 8'h11, 8'h10);
    wr_reg(8'h15, 8'h0A);
    poll(8'h17, 8'h10, 8'h00);
    rchk(8'h15, 8'h08, 8'h00);
    fork
      u_rpvb_link_model.send(20'h00000, 4'h2, 40);
      poll(8'h0F, 8'h20, 8'h20);
    join
    $display("test custom done");
    clr(8'h00);
    e = 0;
    foreach (MODE[i]) begin
      load(MODE[i][27:20], 8'h01);
      u_rpvb_link_model.send(MODE[i][19:0], 4'h1, 1);
      e += (i == 2);
      poll(8'h18, 8'hFF, e[7:0]);
    end
    for (int k = 0; k < 8; k++) begin
      load({2'b00, k[2:0], 3'b001}, 8'h01);
      h = 32'hFFFFFFFF;
      for (int j = 0; j < 10; j++) begin
        for (int b = 0; b < 20; b++) begin
          w[b] = h[TA[k]-1] ^ h[TB[k]-1];
          h = {h[30:0], w[b]};
        end
        u_rpvb_link_model.send(w, 4'h1, 1);
        if (j == 3) clr(8'h00);
      end
      poll(8'h18, 8'hFF, 8'h00);
    end
    $display("test patterns done");
    load(8'h00, 8'h01);
    for (int k = 0; k < 4; k++) begin
      clr(8'h00);
      wr_reg(8'h16, 8'h20 | k[7:0]);
      u_rpvb_link_model.pulse(k, 4'h2, 5);
      poll(8'h18, 8'hFF, 8'h05);
      u_rpvb_link_model.pulse((k + 1) % 4, 4'h2, 3);
      poll(8'h18, 8'hFF, 8'h05);
    end
    u_rpvb_link_model.set_align(1);
    wr_reg(8'h16, 8'h24);
    clr(8'h00);
    poll(8'h18, 8'hFF, 8'h00);
    wr_reg(8'h16, 8'h20);
    clr(8'h01);
    wr_reg(8'h15, 8'h09);
    u_rpvb_link_model.pulse(0, 4'h2, 4100);
    poll(8'h18, 8'hFF, 8'hFF);
    rchk(8'h17, 8'h11, 8'h10);
    $display("test datapath done");
    summarize();
  end
endmodule : rpvb_bench
`default_nettype wire
